/* File: pllcw_config.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - The reference pre-divider is the 10-bit field in word bits 2..11, default 0x07f.
// RULE_02 - The feedback divider is the 12-bit field in word bits 12..23, default 0x07f.
// RULE_03 - The reference path phase delay is word bits 24..26, default zero.
// RULE_04 - The feedback path phase delay is word bits 27..29, default zero.
// RULE_05 - Word bit 30 picks manual (0) or automatic (1) reference selection, default manual.
// RULE_06 - Word bit 31 enables frequency detection when 0 and disables it when 1, default 0.
// RULE_07 - With detection disabled the reference status is held high, else it runs normally.
// RULE_08 - With detection enabled the status goes low when the reference is under about 2 MHz.
// RULE_09 - The host keeps the frequency into the feedback divider under 250 MHz.
// RULE_10 - Frames are 32 bits MSB first and word select bits 1..0 equal to 00 address this word.
// RULE_11 - Latch enable low opens a frame, data leads the clock rise, latch enable rise loads.
// RULE_12 - The port only accepts writes, with no readback, acknowledge or handshake.
// RULE_13 - Every field returns to its default at reset and while power-down is asserted.
module pllcw_config import pllcw_pkg::*; #(
    parameter int LOSS_CYCLES = REF_LOSS_CYCLES
) (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Serial programming link
    input wire logic i_prog_clk,
    input wire logic i_prog_data,
    input wire logic i_prog_latch_enable,
    // Device pins
    input wire logic i_power_down_n,
    input wire logic i_manual_select_secondary,
    input wire logic i_primary_reference_in,
    input wire logic i_secondary_reference_in,
    // Configuration fields
    output logic [PREDIV_W-1:0] o_ref_predivider_field,
    output logic [FBDIV_W-1:0] o_feedback_divider_field,
    output logic [DLY_W-1:0] o_ref_phase_delay_field,
    output logic [DLY_W-1:0] o_feedback_phase_delay_field,
    output logic o_ref_select_auto,
    output logic o_freq_detect_disable,
    // Reference status
    output logic o_status_ref,
    output logic o_ref_is_primary
);

    logic [FRAME_BITS-1:0] shift_word;
    logic le_meta_r;
    logic le_sync_r;
    logic le_prev_r;
    logic pd_meta_r;
    logic pd_sync_r;
    logic msel_meta_r;
    logic msel_sync_r;
    logic pri_present;
    logic sec_present;

    logic [PREDIV_W-1:0] prediv_r;
    logic [FBDIV_W-1:0] fbdiv_r;
    logic [DLY_W-1:0] ref_dly_r;
    logic [DLY_W-1:0] fb_dly_r;
    logic ref_auto_r;
    logic det_dis_r;
    logic status_r;
    logic ref_pri_r;

    // Link side: shifting runs on the programming clock only
    pllcw_serial_rx #(
        .WORD_W(FRAME_BITS)
    ) u_rx (
        .i_prog_clk(i_prog_clk),
        .i_prog_data(i_prog_data),
        .i_prog_latch_enable(i_prog_latch_enable),
        .o_shift_word(shift_word)
    );

    // One detector per reference pin; both paths must behave identically
    logic [1:0] ref_pins;
    logic [1:0] ref_present;
    assign ref_pins = {i_secondary_reference_in, i_primary_reference_in};

    for (genvar ch = 0; ch < 2; ch++) begin : g_det
        pllcw_freq_det #(
            .CNT_W(REF_CNT_W),
            .LOSS_CYCLES(LOSS_CYCLES)
        ) u_det (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_ref_in(ref_pins[ch]),
            .o_present(ref_present[ch])
        );
    end

    assign pri_present = ref_present[0];
    assign sec_present = ref_present[1];

    // Pin synchronisers
    // Latch enable idles high, so its chain resets high: no false edge after reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            le_meta_r <= 1'b1;
            le_sync_r <= 1'b1;
            le_prev_r <= 1'b1;
            pd_meta_r <= 1'b0;
            pd_sync_r <= 1'b0;
            msel_meta_r <= 1'b0;
            msel_sync_r <= 1'b0;
        end else begin
            le_meta_r <= i_prog_latch_enable;
            le_sync_r <= le_meta_r;
            le_prev_r <= le_sync_r;
            pd_meta_r <= i_power_down_n;
            pd_sync_r <= pd_meta_r;
            msel_meta_r <= i_manual_select_secondary;
            msel_sync_r <= msel_meta_r;
        end
    end

    // The synchronised latch-enable edge is the request of the word crossing:
    // the shifter is frozen while latch enable is high, so sampling it here
    // two cycles late is safe. A frame shorter than two system cycles of high
    // latch enable may be missed; that is the price of no handshake back.
    logic le_rise;
    logic sel_match;
    logic do_load;
    logic power_down;
    assign le_rise = le_sync_r & ~le_prev_r; // see RULE_11
    assign sel_match = (shift_word[SEL_LSB +: SEL_W] == SEL_THIS_WORD); // see RULE_10
    assign power_down = ~pd_sync_r;
    assign do_load = le_rise & sel_match & ~power_down;

    // Field decode of the incoming word
    logic [PREDIV_W-1:0] new_prediv;
    logic [FBDIV_W-1:0] new_fbdiv;
    logic [DLY_W-1:0] new_ref_dly;
    logic [DLY_W-1:0] new_fb_dly;
    logic new_ref_auto;
    logic new_det_dis;
    assign new_prediv = shift_word[PREDIV_LSB +: PREDIV_W]; // see RULE_01
    assign new_fbdiv = shift_word[FBDIV_LSB +: FBDIV_W]; // see RULE_02
    assign new_ref_dly = shift_word[REF_DLY_LSB +: DLY_W]; // see RULE_03
    assign new_fb_dly = shift_word[FB_DLY_LSB +: DLY_W]; // see RULE_04
    assign new_ref_auto = shift_word[REF_AUTO_BIT]; // see RULE_05
    assign new_det_dis = shift_word[DET_DIS_BIT]; // see RULE_06

    // Reference selection: automatic falls back to secondary only when
    // primary is gone and secondary is alive
    logic pick_primary;
    logic sel_present;
    logic status_nxt;
    assign pick_primary = ref_auto_r ? (pri_present | ~sec_present) : ~msel_sync_r; // see RULE_05
    assign sel_present = pick_primary ? pri_present : sec_present;
    assign status_nxt = det_dis_r | sel_present; // see RULE_07, see RULE_08

    // Configuration word; write-only, nothing is ever driven back
    always_ff @(posedge i_clk) begin
        if (i_rst || power_down) begin
            prediv_r <= PREDIV_RST; // see RULE_13
            fbdiv_r <= FBDIV_RST;
            ref_dly_r <= DLY_RST;
            fb_dly_r <= DLY_RST;
            ref_auto_r <= REF_AUTO_RST;
            det_dis_r <= DET_DIS_RST;
        end else if (do_load) begin
            prediv_r <= new_prediv; // see RULE_01
            fbdiv_r <= new_fbdiv; // see RULE_02
            ref_dly_r <= new_ref_dly; // see RULE_03
            fb_dly_r <= new_fb_dly; // see RULE_04
            ref_auto_r <= new_ref_auto; // see RULE_05
            det_dis_r <= new_det_dis; // see RULE_06, see RULE_12
        end
    end

    // Status resets high, but the detectors reset to absent, so it drops on the first edge after reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            status_r <= 1'b1;
            ref_pri_r <= 1'b1;
        end else begin
            status_r <= status_nxt; // see RULE_07
            ref_pri_r <= pick_primary;
        end
    end

    assign o_ref_predivider_field = prediv_r;
    assign o_feedback_divider_field = fbdiv_r;
    assign o_ref_phase_delay_field = ref_dly_r;
    assign o_feedback_phase_delay_field = fb_dly_r;
    assign o_ref_select_auto = ref_auto_r;
    assign o_freq_detect_disable = det_dis_r;
    assign o_status_ref = status_r;
    assign o_ref_is_primary = ref_pri_r;

    // Antecedents that look one edge ahead exclude the edge that applies reset
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    load_predivider_a: assert property ( // see RULE_01
        do_load |=> o_ref_predivider_field == $past(new_prediv))
        else $error("pre-divider not loaded from word bits 11..2");

    load_feedback_a: assert property ( // see RULE_02
        do_load |=> o_feedback_divider_field == $past(new_fbdiv))
        else $error("feedback divider not loaded from word bits 23..12");

    load_delays_a: assert property ( // see RULE_03
        do_load |=> o_ref_phase_delay_field == $past(shift_word[26:24])
            && o_feedback_phase_delay_field == $past(shift_word[29:27]))
        else $error("phase delays not loaded from word bits 29..24");

    load_mode_bits_a: assert property ( // see RULE_05
        do_load |=> o_ref_select_auto == $past(shift_word[30])
            && o_freq_detect_disable == $past(shift_word[31]))
        else $error("mode bits not loaded from word bits 31..30");

    other_word_ignored_a: assert property ( // see RULE_10
        (le_rise && !sel_match && pd_sync_r) |=> $stable(o_ref_predivider_field)
            && $stable(o_feedback_divider_field) && $stable(o_freq_detect_disable))
        else $error("word with nonzero select changed this register");

    load_only_on_latch_a: assert property ( // see RULE_11
        (!le_rise && pd_sync_r) |=> $stable(o_ref_predivider_field)
            && $stable(o_ref_phase_delay_field) && $stable(o_ref_select_auto))
        else $error("register changed without a latch enable rise");

    power_down_default_a: assert property ( // see RULE_13
        (!pd_sync_r)[*2] |-> o_ref_predivider_field == 10'h07f
            && o_feedback_divider_field == 12'h07f && o_feedback_phase_delay_field == 3'h0
            && !o_ref_select_auto && !o_freq_detect_disable)
        else $error("power-down did not restore defaults");

    detect_off_high_a: assert property ( // see RULE_07
        $past(o_freq_detect_disable) |-> o_status_ref)
        else $error("status low while frequency detection disabled");

    lost_ref_low_a: assert property ( // see RULE_08
        (!i_rst && !o_freq_detect_disable && !pri_present && !sec_present)
            |=> !o_status_ref)
        else $error("status high with no reference present");

    auto_fallback_a: assert property ( // see RULE_05
        (o_ref_select_auto && !pri_present && sec_present) |=> !o_ref_is_primary)
        else $error("automatic selection did not fall back to secondary");

    // Reset and power-down both land on the defaults
    reset_defaults_a: assert property ( // see RULE_13
        $past(i_rst) |-> o_ref_predivider_field == PREDIV_RST
            && o_feedback_divider_field == FBDIV_RST
            && o_ref_phase_delay_field == DLY_RST
            && o_feedback_phase_delay_field == DLY_RST
            && o_ref_select_auto == REF_AUTO_RST
            && o_freq_detect_disable == DET_DIS_RST
            && o_status_ref && o_ref_is_primary)
        else $error("reset did not restore defaults");

    power_down_clear_a: assert property ( // see RULE_13
        !pd_sync_r |=> o_ref_phase_delay_field == DLY_RST
            && o_feedback_phase_delay_field == DLY_RST
            && o_ref_select_auto == REF_AUTO_RST
            && o_freq_detect_disable == DET_DIS_RST)
        else $error("power-down left a field off its default");

    load_in_power_down_a: assert property ( // see RULE_13
        (le_rise && sel_match && !pd_sync_r) |=> o_ref_predivider_field == PREDIV_RST
            && o_feedback_divider_field == FBDIV_RST)
        else $error("word loaded while power-down was asserted");

    // Only a written word, a reset or a power-down moves the fields
    word_write_only_a: assert property ( // see RULE_12
        ($changed(o_ref_predivider_field) || $changed(o_feedback_divider_field)
            || $changed(o_ref_phase_delay_field) || $changed(o_feedback_phase_delay_field)
            || $changed(o_ref_select_auto) || $changed(o_freq_detect_disable))
            |-> $past(do_load || power_down || i_rst))
        else $error("field changed without a load, reset or power-down");

    other_word_keeps_a: assert property ( // see RULE_10
        (le_rise && !sel_match && pd_sync_r) |=> $stable(o_ref_phase_delay_field)
            && $stable(o_feedback_phase_delay_field) && $stable(o_ref_select_auto))
        else $error("word with nonzero select changed a delay or mode bit");

    load_only_rest_a: assert property ( // see RULE_11
        (!le_rise && pd_sync_r) |=> $stable(o_feedback_divider_field)
            && $stable(o_feedback_phase_delay_field) && $stable(o_freq_detect_disable))
        else $error("feedback field changed without a latch enable rise");

    // Status follows the chosen reference one edge after the detector
    status_follows_ref_a: assert property ( // see RULE_08
        (!i_rst && !o_freq_detect_disable) |=> o_status_ref == $past(sel_present))
        else $error("status does not follow the selected reference");

    detect_off_load_a: assert property ( // see RULE_07
        (do_load && new_det_dis) |-> ##2 o_status_ref)
        else $error("status not held high after detection was disabled");

    auto_status_a: assert property ( // see RULE_08
        (!i_rst && o_ref_select_auto && !o_freq_detect_disable && (pri_present || sec_present))
            |=> o_status_ref)
        else $error("status low in automatic mode with a reference present");

    manual_select_a: assert property ( // see RULE_05
        (!i_rst && !o_ref_select_auto) |=> o_ref_is_primary != $past(msel_sync_r))
        else $error("manual selection not taken from the select pin");

    auto_primary_a: assert property ( // see RULE_05
        (!i_rst && o_ref_select_auto && pri_present) |=> o_ref_is_primary)
        else $error("automatic selection left a live primary");

    auto_none_left_a: assert property ( // see RULE_05
        (!i_rst && o_ref_select_auto && !pri_present && !sec_present) |=> o_ref_is_primary)
        else $error("automatic selection left primary with no reference present");

endmodule // pllcw_config

/* File: pllcw_freq_det.sv */
`timescale 1ns/1ps
// Flags a reference as present while its rising edges come often enough
module pllcw_freq_det import pllcw_pkg::*; #(
    parameter int CNT_W = REF_CNT_W,
    parameter int LOSS_CYCLES = REF_LOSS_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Reference pin
    input wire logic i_ref_in,
    // Detector result
    output logic o_present
);

    logic meta_r;
    logic sync_r;
    logic prev_r;
    logic [CNT_W-1:0] cnt_r;
    logic present_r;
    logic edge_seen;
    logic expired;

    assign edge_seen = sync_r & ~prev_r;
    assign expired = (cnt_r == CNT_W'(LOSS_CYCLES - 1));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
            cnt_r <= '0;
            present_r <= 1'b0;
        end else begin
            meta_r <= i_ref_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
            if (edge_seen) begin
                cnt_r <= '0;
                present_r <= 1'b1;
            end else if (expired) begin
                present_r <= 1'b0; // see RULE_08
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign o_present = present_r;

endmodule // pllcw_freq_det

/* File: pllcw_host_model.sv */
`timescale 1ns/1ps
// Host on the far side of the programming port; write-only, it has no inputs
module pllcw_host_model #(
    parameter int HALF_NS = 15
) (
    // Serial link
    output logic o_prog_clk,
    output logic o_prog_data,
    output logic o_prog_latch_enable
);
    initial begin
        o_prog_clk = 1'b0;
        o_prog_data = 1'b0;
        o_prog_latch_enable = 1'b1;
    end

    // Clock stands still outside frames, as a real host would leave it
    // Prescaler is set in another word, kept legal by this host
    task automatic send(input logic [31:0] word);
        // Off the system clock edges: the link is unrelated in phase
        #4;
        o_prog_latch_enable = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            o_prog_data = word[i];
            #HALF_NS o_prog_clk = 1'b1;
            #HALF_NS o_prog_clk = 1'b0;
        end
        #HALF_NS o_prog_latch_enable = 1'b1;
        // Data no longer valid once the frame is closed
        o_prog_data = ~o_prog_data;
        #HALF_NS;
    endtask
endmodule // pllcw_host_model

/* File: pllcw_pkg.sv */
package pllcw_pkg;

    // Frame layout
    localparam int FRAME_BITS = 32;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_THIS_WORD = 2'h0;

    // Field positions and widths
    localparam int PREDIV_LSB = 2;
    localparam int PREDIV_W = 10;
    localparam int FBDIV_LSB = 12;
    localparam int FBDIV_W = 12;
    localparam int REF_DLY_LSB = 24;
    localparam int FB_DLY_LSB = 27;
    localparam int DLY_W = 3;
    localparam int REF_AUTO_BIT = 30;
    localparam int DET_DIS_BIT = 31;

    // Values after power-up or power-down
    localparam logic [9:0] PREDIV_RST = 10'h07f;
    localparam logic [11:0] FBDIV_RST = 12'h07f;
    localparam logic [2:0] DLY_RST = 3'h0;
    localparam logic REF_AUTO_RST = 1'b0;
    localparam logic DET_DIS_RST = 1'b0;

    // Reference loss threshold: a reference slower than this is absent
    localparam int SYS_CLK_KHZ = 200000;
    localparam int REF_MIN_KHZ = 2000;
    localparam int REF_LOSS_CYCLES = SYS_CLK_KHZ / REF_MIN_KHZ;
    localparam int REF_CNT_W = 8;

endpackage

/* File: pllcw_serial_rx.sv */
`timescale 1ns/1ps
// Shifter on the programming clock; MSB arrives first and ends up in bit 31
module pllcw_serial_rx import pllcw_pkg::*; #(
    parameter int WORD_W = FRAME_BITS
) (
    // Serial link
    input wire logic i_prog_clk,
    input wire logic i_prog_data,
    input wire logic i_prog_latch_enable,
    // Shifted word, stable while latch enable is high
    output logic [WORD_W-1:0] o_shift_word
);

    logic [WORD_W-1:0] shift_r;

    // Only the last 32 bits count; the link clock may stop between frames
    always_ff @(posedge i_prog_clk) begin
        if (!i_prog_latch_enable) begin
            shift_r <= {shift_r[WORD_W-2:0], i_prog_data}; // see RULE_10, see RULE_11
        end
    end

    assign o_shift_word = shift_r;

endmodule // pllcw_serial_rx

/* File: testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

module testbench;
    localparam logic [31:0] DEF_WORD = 32'h0007f1fc;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic pd_n = 1'b1;
    logic man_sec = 1'b0;
    logic pri = 1'b0;
    logic sec = 1'b0;
    logic pri_en = 1'b1;
    logic sec_en = 1'b1;
    logic [3:0] ref_cnt = 4'h0;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    wire prog_clk, prog_data, prog_le;
    wire [9:0] pre_f;
    wire [11:0] fb_f;
    wire [2:0] rdly_f, fdly_f;
    wire auto_f, det_dis_f, stat, is_pri;

    always #2.5 i_clk = ~i_clk;

    // References toggle every 5 cycles, well inside the loss window
    always @(posedge i_clk) begin
        ref_cnt <= (ref_cnt == 4'h4) ? 4'h0 : ref_cnt + 4'h1;
        if (ref_cnt == 4'h4) begin
            pri <= pri_en ? ~pri : 1'b0;
            sec <= sec_en ? ~sec : 1'b0;
        end
    end

    pllcw_host_model host_u (
        .o_prog_clk(prog_clk),
        .o_prog_data(prog_data),
        .o_prog_latch_enable(prog_le)
    );

    pllcw_config #(.LOSS_CYCLES(20)) dut_u (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_prog_clk(prog_clk),
        .i_prog_data(prog_data),
        .i_prog_latch_enable(prog_le),
        .i_power_down_n(pd_n),
        .i_manual_select_secondary(man_sec),
        .i_primary_reference_in(pri),
        .i_secondary_reference_in(sec),
        .o_ref_predivider_field(pre_f),
        .o_feedback_divider_field(fb_f),
        .o_ref_phase_delay_field(rdly_f),
        .o_feedback_phase_delay_field(fdly_f),
        .o_ref_select_auto(auto_f),
        .o_freq_detect_disable(det_dis_f),
        .o_status_ref(stat),
        .o_ref_is_primary(is_pri)
    );

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic check_fields(input logic [31:0] w);
        `CHK(pre_f, w[11:2])
        `CHK(fb_f, w[23:12])
        `CHK(rdly_f, w[26:24])
        `CHK(fdly_f, w[29:27])
        `CHK(auto_f, w[30])
        `CHK(det_dis_f, w[31])
    endtask

    // Load lands a few system edges after latch enable rises
    task automatic write_word(input logic [31:0] w);
        host_u.send(w);
        wait_clk(8);
    endtask

    localparam logic [31:0] W1 = 32'h2d5a5acc;
    localparam logic [31:0] W2 = 32'hc1234568;
    localparam logic [31:0] W3 = 32'h4abcd124;

    initial begin
        wait_clk(8);
        i_rst <= 1'b0;
        wait_clk(2);
        check_fields(DEF_WORD);
        wait_clk(40);
        `CHK(stat, 1'b1)
        `CHK(is_pri, 1'b1)
        write_word(W1);
        check_fields(W1);
        for (int s = 1; s < 4; s++) begin
            write_word({30'h3fffffff, s[1:0]});
            check_fields(W1);
        end
        pri_en <= 1'b0;
        wait_clk(40);
        `CHK(stat, 1'b0)
        man_sec <= 1'b1;
        wait_clk(10);
        `CHK(stat, 1'b1)
        `CHK(is_pri, 1'b0)
        sec_en <= 1'b0;
        wait_clk(40);
        `CHK(stat, 1'b0)
        write_word(W2);
        check_fields(W2);
        `CHK(stat, 1'b1)
        pd_n <= 1'b0;
        wait_clk(6);
        check_fields(DEF_WORD);
        write_word(W1);
        check_fields(DEF_WORD);
        pd_n <= 1'b1;
        wait_clk(4);
        write_word(W1);
        check_fields(W1);
        // Automatic mode: dead primary falls back, live primary wins over the pin
        sec_en <= 1'b1;
        write_word(W3);
        check_fields(W3);
        `CHK(stat, 1'b1)
        `CHK(is_pri, 1'b0)
        pri_en <= 1'b1;
        wait_clk(30);
        `CHK(is_pri, 1'b1)
        `CHK(stat, 1'b1)
        i_rst <= 1'b1;
        wait_clk(3);
        i_rst <= 1'b0;
        wait_clk(2);
        check_fields(DEF_WORD);
        close_out();
    end
endmodule // testbench
